// file: logic/lfo_defines.vh
`ifndef LFO_DEFINES_VH
`define LFO_DEFINES_VH
`define LFO_ADDR_LF_CTRL 8'h86
`define LFO_ADDR_MULT 8'hb9
`define LFO_MULT_READ 8'he0
`define LFO_BIT_EN 7
`define LFO_BIT_RDY 6
`define LFO_TRIM_HI 5
`define LFO_TRIM_LO 2
`define LFO_DIV_HI 1
`define LFO_DIV_LO 0
`define LFO_TRIM_RESET 4'h8
// Settling time, 100 us of 25 MHz cycles
`define LFO_STAB_CYC 12'h9c4
// Half period at trim 0000b, about 80 kHz undivided
`define LFO_BASE_HALF 9'h09c
`endif

// file: logic/lfo_ctrl.v
`include "lfo_defines.vh"
module lfo_ctrl (
  input wire clk, // 25 MHz clock
  input wire rstn, // Async reset, active low
  input wire ce, // Clock enable
  input wire [7:0] sfr_addr, // Register address
  input wire sfr_wr, // Write strobe
  input wire [7:0] sfr_wdata, // Write data
  input wire sfr_rd, // Read strobe
  input wire t2_capture_mode, // Timer 2 capture mode
  input wire t3_capture_mode, // Timer 3 capture mode
  input wire [15:0] t2_count, // Timer 2 count high:low
  input wire [15:0] t3_count, // Timer 3 count high:low
  output reg [7:0] sfr_rdata, // Read data
  output reg lf_clk, // Divided oscillator output
  output reg lf_running, // Oscillator enabled
  output reg t2_capture, // Timer 2 capture pulse
  output reg t3_capture, // Timer 3 capture pulse
  output reg [15:0] t2_reload, // Timer 2 reload high:low
  output reg [15:0] t3_reload // Timer 3 reload high:low
);
  // Register fields
  reg en_ff;
  reg rdy_ff;
  reg [3:0] trim_ff;
  reg [1:0] div_ff;

  // Settling counter and oscillator model
  reg [11:0] stab_ff;
  reg [8:0] half_ff;
  reg [2:0] dcnt_ff;
  reg osc_ff;
  reg prev_ff;

  // Next-state values
  reg nxt_en;
  reg nxt_rdy;
  reg [3:0] nxt_trim;
  reg [1:0] nxt_div;
  reg [11:0] nxt_stab;
  reg [8:0] nxt_half;
  reg [2:0] nxt_dcnt;
  reg nxt_osc;
  reg nxt_lf;
  reg [7:0] nxt_rdata;

  wire wr_lf;
  wire div_change;
  wire half_end;
  wire fall_seen;
  wire rise_seen;
  wire [8:0] half_len;
  wire [2:0] div_mask;

  // Register address match
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Divider counter bits used for a divider select code
  function [2:0] mask_of;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: mask_of = 3'h7; // Divide by 8
        2'h1: mask_of = 3'h3; // Divide by 4
        2'h2: mask_of = 3'h1; // Divide by 2
        default: mask_of = 3'h0; // Divide by 1
      endcase
    end
  endfunction

  assign wr_lf = sfr_wr && addr_hit(sfr_addr, `LFO_ADDR_LF_CTRL);
  assign div_change = wr_lf &&
    (sfr_wdata[`LFO_DIV_HI:`LFO_DIV_LO] != div_ff);
  assign half_len = `LFO_BASE_HALF + {5'h00, trim_ff};
  assign half_end = (half_ff >= half_len - 9'h001);
  assign div_mask = mask_of(div_ff);
  assign fall_seen = prev_ff && !lf_clk;
  assign rise_seen = !prev_ff && lf_clk;

  // Writable fields of the oscillator control register
  always @* begin
    nxt_en = en_ff;
    nxt_trim = trim_ff;
    nxt_div = div_ff;
    if (wr_lf) begin
      nxt_en = sfr_wdata[`LFO_BIT_EN];
      nxt_trim = sfr_wdata[`LFO_TRIM_HI:`LFO_TRIM_LO];
      nxt_div = sfr_wdata[`LFO_DIV_HI:`LFO_DIV_LO];
    end
  end

  // Divider change restarts settling; clear wins over set
  always @* begin
    nxt_rdy = rdy_ff;
    nxt_stab = stab_ff;
    if (div_change) begin
      nxt_rdy = 1'b0;
      nxt_stab = 12'h000;
    end else if (en_ff && !rdy_ff) begin
      if (stab_ff == `LFO_STAB_CYC - 12'h001)
        nxt_rdy = 1'b1;
      else
        nxt_stab = stab_ff + 12'h001;
    end
  end

  // Oscillator half-period counter and post-divider count
  always @* begin
    nxt_half = half_ff;
    nxt_osc = osc_ff;
    nxt_dcnt = dcnt_ff;
    if (!en_ff) begin
      nxt_half = 9'h000;
      nxt_osc = 1'b0;
      nxt_dcnt = 3'h0;
    end else if (half_end) begin
      nxt_half = 9'h000;
      nxt_osc = ~osc_ff;
      if (osc_ff)
        nxt_dcnt = dcnt_ff + 3'h1;
    end else begin
      nxt_half = half_ff + 9'h001;
    end
  end

  // Divided output, high in the upper half of the count; the oscillator itself at divide by 1
  always @* begin
    if (div_mask == 3'h0)
      nxt_lf = osc_ff;
    else
      nxt_lf = ((dcnt_ff & div_mask) > (div_mask >> 1));
  end

  // Read data, held until the next read
  always @* begin
    nxt_rdata = sfr_rdata;
    if (sfr_rd) begin
      if (addr_hit(sfr_addr, `LFO_ADDR_MULT))
        nxt_rdata = `LFO_MULT_READ;
      else if (addr_hit(sfr_addr, `LFO_ADDR_LF_CTRL))
        nxt_rdata = {en_ff, rdy_ff, trim_ff, div_ff};
      else
        nxt_rdata = 8'h00;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_ff <= 1'b0;
      trim_ff <= `LFO_TRIM_RESET;
      div_ff <= 2'h0;
    end else if (ce) begin
      en_ff <= nxt_en;
      trim_ff <= nxt_trim;
      div_ff <= nxt_div;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdy_ff <= 1'b0;
      stab_ff <= 12'h000;
    end else if (ce) begin
      rdy_ff <= nxt_rdy;
      stab_ff <= nxt_stab;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      half_ff <= 9'h000;
      osc_ff <= 1'b0;
      dcnt_ff <= 3'h0;
    end else if (ce) begin
      half_ff <= nxt_half;
      osc_ff <= nxt_osc;
      dcnt_ff <= nxt_dcnt;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lf_clk <= 1'b0;
      prev_ff <= 1'b0;
      lf_running <= 1'b0;
    end else if (ce) begin
      lf_clk <= nxt_lf;
      prev_ff <= lf_clk;
      lf_running <= en_ff;
    end
  end

  // Timer 2 captures on a falling output edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t2_capture <= 1'b0;
      t2_reload <= 16'h0000;
    end else if (ce) begin
      t2_capture <= t2_capture_mode && fall_seen;
      if (t2_capture_mode && fall_seen)
        t2_reload <= t2_count;
    end
  end

  // Timer 3 captures on a rising output edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t3_capture <= 1'b0;
      t3_reload <= 16'h0000;
    end else if (ce) begin
      t3_capture <= t3_capture_mode && rise_seen;
      if (t3_capture_mode && rise_seen)
        t3_reload <= t3_count;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      sfr_rdata <= 8'h00;
    else if (ce)
      sfr_rdata <= nxt_rdata;
  end
endmodule // lfo_ctrl

// file: tb/lfo_checker.sv
module lfo_checker(input wire clk,rstn,ce,sfr_rd,lf_clk,lf_running,
  t2_capture_mode,t3_capture_mode,t2_capture,t3_capture,
  input wire [7:0] sfr_addr,sfr_rdata,input wire [15:0] t2_count,t2_reload);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_rm; ce && sfr_rd && sfr_addr == 8'hb9; endsequence
  property p_en; s_rm |=> sfr_rdata[7]; endproperty
  property p_in; s_rm |=> sfr_rdata[6]; endproperty
  property p_lk; s_rm |=> sfr_rdata[5]; endproperty
  property p_sl; s_rm |=> sfr_rdata[4:0] == 5'h00; endproperty
  property p_c2; ce && t2_capture_mode && $fell(lf_clk) |=> t2_capture;
  endproperty
  property p_c3; ce && t3_capture_mode && $rose(lf_clk) |=> t3_capture;
  endproperty
  property p_rl; t2_capture |-> t2_reload == $past(t2_count); endproperty
  property p_of; !lf_running [*2] |=> $stable(lf_clk); endproperty
  a_en: assert property (p_en) else $error("mult enable");
  a_in: assert property (p_in) else $error("mult init");
  a_lk: assert property (p_lk) else $error("mult locked");
  a_sl: assert property (p_sl) else $error("mult select");
  a_c2: assert property (p_c2) else $error("t2 capture");
  a_c3: assert property (p_c3) else $error("t3 capture");
  a_rl: assert property (p_rl) else $error("t2 reload");
  a_of: assert property (p_of) else $error("clock while off");
endmodule // lfo_checker
bind lfo_ctrl lfo_checker lfo_checker_inst(.*);

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk=0, rstn=0, wr=0, rd=0;
  reg [7:0] a=0, wd=0;
  reg [15:0] cyc=0;
  wire [7:0] q;
  wire lc, run, c2, c3;
  wire [15:0] r3;
  int n_errors=0, compares=0, p[4], pf;
  lfo_ctrl lfo_ctrl_inst(.clk, .rstn, .ce(1'b1), .sfr_addr(a), .sfr_wr(wr),
    .sfr_wdata(wd), .sfr_rd(rd), .t2_capture_mode(1'b1),
    .t3_capture_mode(1'b1), .t2_count(cyc), .t3_count(cyc), .sfr_rdata(q),
    .lf_clk(lc), .lf_running(run), .t2_capture(c2), .t3_capture(c3),
    .t2_reload(), .t3_reload(r3));
  initial forever #20 clk = ~clk;
  task chk(input [15:0] s, e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t got %h exp %h", $time, s, e);
    end
  endtask
  task w(input [7:0] ad, d);
    @(posedge clk); wr <= 1; a <= ad; wd <= d;
    @(posedge clk); wr <= 0;
  endtask
  task r(input [7:0] ad, e);
    @(posedge clk); rd <= 1; a <= ad;
    @(posedge clk); rd <= 0;
    #1 chk(q, e);
  endtask
  // Period from successive rising-edge captures, first one discarded
  task per(output int v);
    reg [15:0] x;
    @(posedge c3); @(posedge c3);
    #1 x = r3;
    @(posedge c3);
    #1 v = r3 - x;
  endtask
  task test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    r(8'h86, 8'h20);
    w(8'hb9, 8'h00); r(8'hb9, 8'he0); r(8'h10, 8'h00);
    w(8'h86, 8'h83); r(8'h86, 8'h83);
    repeat (2600) @(posedge clk); r(8'h86, 8'hc3);
    w(8'h86, 8'hbf); r(8'h86, 8'hff); per(pf);
    w(8'h86, 8'h82); r(8'h86, 8'h82);
    for (int d = 0; d < 4; d++) begin w(8'h86, 8'(8'h80 + d)); per(p[d]); end
    chk(pf > p[3], 1);
    chk(p[3], 16'h0138);
    for (int d = 0; d < 3; d++) chk(p[d], p[3] << (3 - d));
    w(8'h86, 8'h00); r(8'h86, 8'h00); chk(run, 0);
    test_done;
  end
endmodule // tb
